// File: hw/flm_pkg.sv
// Shared constants and types of the loop modem framing block
`default_nettype none
package flm_pkg;
   localparam int unsigned CLK_HZ        = 250_000_000;
   localparam int unsigned MARK_HZ       = 1200;
   localparam int unsigned SPACE_HZ      = 2200;
   localparam int unsigned BAUD_RATE     = 1200;
   localparam int unsigned BIT_TIME_US   = 833;
   localparam int unsigned BIT_CYCLES    = CLK_HZ / BAUD_RATE;
   localparam int unsigned MARK_HALF     = CLK_HZ / (2 * MARK_HZ);
   localparam int unsigned SPACE_HALF    = CLK_HZ / (2 * SPACE_HZ);
   localparam int unsigned DECIDE_CYCLES =
      (CLK_HZ / MARK_HZ + CLK_HZ / SPACE_HZ) / 2;
   localparam int unsigned DATA_BITS     = 8;
   localparam int unsigned FRAME_BITS    = 11;
   localparam int unsigned VALUE_BITS    = 16;
   localparam int unsigned LOOP_MIN_UA   = 4000;
   localparam int unsigned LOOP_MAX_UA   = 20000;
   localparam int unsigned LOOP_SPAN_UA  = LOOP_MAX_UA - LOOP_MIN_UA;
   localparam int unsigned FAULT_LOW_UA  = 3600;
   localparam int unsigned FAULT_HIGH_UA = 21000;
   localparam int unsigned LOOP_UA_BITS  = 15;
   localparam logic        MARK_LEVEL    = 1'b1;
   localparam logic        SPACE_LEVEL   = 1'b0;

   typedef enum logic [1:0] {
      RX_IDLE,
      RX_START,
      RX_DATA,
      RX_STOP
   } flm_rx_state_t;
endpackage
`default_nettype wire

// File: hw/flm_tone_if.sv
// Carrier between the framer and the tone generator
`timescale 1ns/100ps
`default_nettype none
interface flm_tone_if;
   logic enable;
   logic bitValue;
   logic tone;

   modport gen  (input enable, input bitValue, output tone);
   modport user (output enable, output bitValue, input tone);
endinterface
`default_nettype wire

// File: hw/flm_tone_gen.sv
// Phase-continuous two-tone square wave generator
`timescale 1ns/100ps
`default_nettype none
module flm_tone_gen #(
   parameter int unsigned MARK_HALF  = flm_pkg::MARK_HALF,
   parameter int unsigned SPACE_HALF = flm_pkg::SPACE_HALF
) (
   input  wire logic   clock,
   input  wire logic   arst_n,
   flm_tone_if.gen     tonePort
);
   localparam int unsigned HW = $clog2(MARK_HALF + 1);

   if (MARK_HALF < 2 || SPACE_HALF < 2 || SPACE_HALF >= MARK_HALF) begin : g_chk
      $error("Tone half periods unusable");
   end

   typedef struct packed {
      logic          level;
      logic [HW-1:0] cnt;
   } flm_gen_state_t;

   flm_gen_state_t state_reg;
   flm_gen_state_t state_next;
   logic [HW-1:0]  halfLast;

   always_comb begin
      state_next = state_reg;
      // Tone by bit value
      halfLast = (tonePort.bitValue == flm_pkg::MARK_LEVEL) ?
                 HW'(MARK_HALF - 1) : HW'(SPACE_HALF - 1);
      if (!tonePort.enable) begin
         state_next.level = 1'b0;
         state_next.cnt   = '0;
      end else if (state_reg.cnt >= halfLast) begin
         // Switch at a half period edge so the phase stays continuous
         state_next.level = ~state_reg.level;
         state_next.cnt   = '0;
      end else begin
         state_next.cnt = state_reg.cnt + HW'(1);
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign tonePort.tone = state_reg.level;
endmodule
`default_nettype wire

// File: hw/fsk_loop_modem_framing.sv
// Loop modem framer, demodulator, responder gate and current mapping
// Function
// - A one bit is sent as a 1200 Hz tone and a received 1200 Hz tone reads as one.
// - A zero bit is sent as a 2200 Hz tone and a received 2200 Hz tone reads as zero.
// - Both directions run at 1200 symbols per second, about 833 us per bit.
// - Each byte carries eight data bits, then an odd parity bit, then one stop bit.
// - The host opens each exchange with a command and the transmitter answers only after it.
// - The process value maps linearly to loop current, 4 mA at minimum and 20 mA at maximum.
`timescale 1ns/100ps
`default_nettype none
module fsk_loop_modem_framing #(
   parameter int unsigned BIT_CYCLES    = flm_pkg::BIT_CYCLES,
   parameter int unsigned MARK_HALF     = flm_pkg::MARK_HALF,
   parameter int unsigned SPACE_HALF    = flm_pkg::SPACE_HALF,
   parameter int unsigned DECIDE_CYCLES = flm_pkg::DECIDE_CYCLES,
   parameter int unsigned VALUE_BITS    = flm_pkg::VALUE_BITS
) (
   input  wire logic                              clock,
   input  wire logic                              arst_n,
   input  wire logic [VALUE_BITS-1:0]             processValue,
   output var  logic [flm_pkg::LOOP_UA_BITS-1:0]  loopMicroAmp,
   input  wire logic                              rxTone,
   output var  logic                              demodBit,
   output var  logic                              txTone,
   output var  logic                              txCarrierOn,
   input  wire logic                              txValid,
   input  wire logic [flm_pkg::DATA_BITS-1:0]     txData,
   input  wire logic                              txLast,
   output var  logic                              txReady,
   output var  logic                              rxValid,
   output var  logic [flm_pkg::DATA_BITS-1:0]     rxData,
   output var  logic                              rxParityErr,
   output var  logic                              rxFrameErr,
   output var  logic                              responseArmed
);
   localparam int unsigned DB   = flm_pkg::DATA_BITS;
   localparam int unsigned FB   = flm_pkg::FRAME_BITS;
   localparam int unsigned CW   = $clog2(BIT_CYCLES + 1);
   localparam int unsigned PMAX = 4 * MARK_HALF;
   localparam int unsigned PW   = $clog2(PMAX + 1);
   localparam int unsigned UW   = flm_pkg::LOOP_UA_BITS;

   if (BIT_CYCLES < 4 || DECIDE_CYCLES >= PMAX || DECIDE_CYCLES < 2 ||
       VALUE_BITS < 1 || VALUE_BITS > 16) begin : g_chk
      $error("Modem parameters unusable");
   end

   typedef struct packed {
      logic                  txBusy;
      logic [FB-1:0]         txShift;
      logic [3:0]            txLeft;
      logic [CW-1:0]         txCnt;
      logic                  txEndResp;
      logic                  armed;
      logic                  toneLast;
      logic [PW-1:0]         perCnt;
      logic                  demod;
      flm_pkg::flm_rx_state_t rxState;
      logic [CW-1:0]         rxCnt;
      logic [3:0]            rxIdx;
      logic [DB:0]           rxShift;
      logic                  rxValid;
      logic [DB-1:0]         rxData;
      logic                  rxParErr;
      logic                  rxFrmErr;
      logic [UW-1:0]         loopUa;
   } flm_state_t;

   flm_state_t state_reg;
   flm_state_t state_next;
   logic [31:0] scaled;
   logic        armClear;
   logic        armSet;

   flm_tone_if toneBus ();

   flm_tone_gen #(
      .MARK_HALF  (MARK_HALF),
      .SPACE_HALF (SPACE_HALF)
   ) u_tone (
      .clock    (clock),
      .arst_n   (arst_n),
      .tonePort (toneBus.gen)
   );

   // Answer gate
   assign txReady = state_reg.armed && !state_reg.txBusy &&
                    (state_reg.rxState == flm_pkg::RX_IDLE);

   always_comb begin
      state_next = state_reg;
      armClear   = 1'b0;
      armSet     = 1'b0;
      scaled     = '0;
      state_next.rxValid = 1'b0;

      // Transmit framer
      if (txValid && txReady) begin
         state_next.txShift   = {1'b1, ~^txData, txData, 1'b0};
         state_next.txLeft    = 4'(FB);
         state_next.txCnt     = CW'(BIT_CYCLES - 1);
         state_next.txBusy    = 1'b1;
         state_next.txEndResp = txLast;
      end else if (state_reg.txBusy) begin
         if (state_reg.txCnt == '0) begin
            state_next.txShift = {1'b1, state_reg.txShift[FB-1:1]};
            state_next.txLeft  = state_reg.txLeft - 4'd1;
            state_next.txCnt   = CW'(BIT_CYCLES - 1);
            if (state_reg.txLeft == 4'd1) begin
               state_next.txBusy = 1'b0;
               armClear = state_reg.txEndResp;
            end
         end else begin
            state_next.txCnt = state_reg.txCnt - CW'(1);
         end
      end

      // Tone period discriminator
      state_next.toneLast = rxTone;
      if (rxTone && !state_reg.toneLast) begin
         state_next.demod = (state_reg.perCnt > PW'(DECIDE_CYCLES)) ?
                            flm_pkg::MARK_LEVEL : flm_pkg::SPACE_LEVEL;
         state_next.perCnt = '0;
      end else if (state_reg.perCnt != PW'(PMAX)) begin
         state_next.perCnt = state_reg.perCnt + PW'(1);
      end else begin
         // No carrier rests at mark so the receiver stays idle
         state_next.demod = flm_pkg::MARK_LEVEL;
      end

      // Receive deframer
      unique case (state_reg.rxState)
         flm_pkg::RX_IDLE: begin
            if (state_reg.demod == flm_pkg::SPACE_LEVEL) begin
               state_next.rxState = flm_pkg::RX_START;
               state_next.rxCnt   = CW'(BIT_CYCLES / 2 - 1);
            end
         end
         flm_pkg::RX_START: begin
            if (state_reg.rxCnt != '0) begin
               state_next.rxCnt = state_reg.rxCnt - CW'(1);
            end else if (state_reg.demod == flm_pkg::MARK_LEVEL) begin
               // Glitch shorter than half a bit is dropped
               state_next.rxState = flm_pkg::RX_IDLE;
            end else begin
               state_next.rxState = flm_pkg::RX_DATA;
               state_next.rxCnt   = CW'(BIT_CYCLES - 1);
               state_next.rxIdx   = '0;
            end
         end
         flm_pkg::RX_DATA: begin
            if (state_reg.rxCnt != '0) begin
               state_next.rxCnt = state_reg.rxCnt - CW'(1);
            end else begin
               state_next.rxShift = {state_reg.demod,
                                     state_reg.rxShift[DB:1]};
               state_next.rxIdx   = state_reg.rxIdx + 4'd1;
               state_next.rxCnt   = CW'(BIT_CYCLES - 1);
               if (state_reg.rxIdx == 4'(DB)) begin
                  state_next.rxState = flm_pkg::RX_STOP;
               end
            end
         end
         flm_pkg::RX_STOP: begin
            if (state_reg.rxCnt != '0) begin
               state_next.rxCnt = state_reg.rxCnt - CW'(1);
            end else begin
               state_next.rxState  = flm_pkg::RX_IDLE;
               state_next.rxValid  = 1'b1;
               state_next.rxData   = state_reg.rxShift[DB-1:0];
               state_next.rxParErr = ~^state_reg.rxShift;
               state_next.rxFrmErr = (state_reg.demod != flm_pkg::MARK_LEVEL);
               armSet = 1'b1;
            end
         end
      endcase

      // A command landing as the last answer bit ends keeps the gate open
      if (armClear) begin
         state_next.armed = 1'b0;
      end
      if (armSet) begin
         state_next.armed = 1'b1;
      end

      scaled = (32'(processValue) + 32'd1) * 32'(flm_pkg::LOOP_SPAN_UA);
      state_next.loopUa = UW'(flm_pkg::LOOP_MIN_UA + (scaled >> VALUE_BITS));
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_reg         <= '0;
         state_reg.demod   <= flm_pkg::MARK_LEVEL;
         state_reg.txShift <= '1;
         state_reg.rxState <= flm_pkg::RX_IDLE;
         state_reg.loopUa  <= UW'(flm_pkg::LOOP_MIN_UA);
      end else begin
         state_reg <= state_next;
      end
   end

   // Carrier follows the bit on the line
   assign toneBus.enable   = state_reg.txBusy;
   assign toneBus.bitValue = state_reg.txBusy ? state_reg.txShift[0] :
                             flm_pkg::MARK_LEVEL;

   assign txTone        = toneBus.tone;
   assign txCarrierOn   = state_reg.txBusy;
   assign demodBit      = state_reg.demod;
   assign rxValid       = state_reg.rxValid;
   assign rxData        = state_reg.rxData;
   assign rxParityErr   = state_reg.rxParErr;
   assign rxFrameErr    = state_reg.rxFrmErr;
   assign responseArmed = state_reg.armed;
   assign loopMicroAmp  = state_reg.loopUa;
endmodule
`default_nettype wire

// File: testbench/flm_monitor.sv
// Port assertions for the loop modem framer
`timescale 1ns/100ps
`default_nettype none
module flm_monitor #(
   parameter int unsigned BIT_CYCLES = flm_pkg::BIT_CYCLES,
   parameter int unsigned MARK_HALF  = flm_pkg::MARK_HALF,
   parameter int unsigned VALUE_BITS = flm_pkg::VALUE_BITS
) (
   input wire logic                   clock,
   input wire logic                   arst_n,
   input wire logic [VALUE_BITS-1:0]  processValue,
   input wire logic [14:0]            loopMicroAmp,
   input wire logic                   rxTone,
   input wire logic                   demodBit,
   input wire logic                   txTone,
   input wire logic                   txCarrierOn,
   input wire logic                   txValid,
   input wire logic                   txReady,
   input wire logic                   rxValid,
   input wire logic                   rxParityErr,
   input wire logic                   responseArmed
);
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   logic [31:0] carCnt;
   logic [31:0] quietCnt;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         carCnt <= '0;
         quietCnt <= '0;
      end else begin
         carCnt <= txCarrierOn ? carCnt + 1 : '0;
         quietCnt <= $changed(rxTone) ? '0 : quietCnt + 1;
      end
   end
   carrier_len_a: assert property ($fell(txCarrierOn) |->
      carCnt == 11 * BIT_CYCLES) else $error("character length wrong");
   take_start_a: assert property (txValid && txReady |=>
      txCarrierOn && !txReady) else $error("taken byte not sent");
   ready_cond_a: assert property (txReady |->
      responseArmed && !txCarrierOn) else $error("ready while not armed");
   arm_clear_a: assert property ($fell(responseArmed) |->
      $fell(txCarrierOn)) else $error("arm dropped outside byte end");
   rx_pulse_a: assert property (rxValid |->
      responseArmed ##1 !rxValid) else $error("receive pulse wrong");
   loop_map_a: assert property (1'b1 |=> loopMicroAmp ==
      15'(4000 + (((32'($past(processValue)) + 1) * 16000) >> VALUE_BITS)))
      else $error("loop current mapping wrong");
   tone_hold_a: assert property (txCarrierOn &&
      $changed(txTone) |=> ($stable(txTone) || !txCarrierOn)[*5])
      else $error("tone too fast");
   quiet_mark_a: assert property (quietCnt > 4 * MARK_HALF + 4
      |-> demodBit) else $error("silent line not read as mark");
   tone_off_a: assert property (!txCarrierOn &&
      !$past(txCarrierOn) |-> !txTone) else $error("tone without carrier");
   cover property (rxValid && rxParityErr);
   cover property ($fell(responseArmed));
   cover property (txValid && txReady);
endmodule
bind fsk_loop_modem_framing flm_monitor #(.BIT_CYCLES(BIT_CYCLES),
   .MARK_HALF(MARK_HALF), .VALUE_BITS(VALUE_BITS)) mon_u (
   .clock         (clock),
   .arst_n        (arst_n),
   .processValue  (processValue),
   .loopMicroAmp  (loopMicroAmp),
   .rxTone        (rxTone),
   .demodBit      (demodBit),
   .txTone        (txTone),
   .txCarrierOn   (txCarrierOn),
   .txValid       (txValid),
   .txReady       (txReady),
   .rxValid       (rxValid),
   .rxParityErr   (rxParityErr),
   .responseArmed (responseArmed)
);
`default_nettype wire

// File: testbench/flm_loop_host.sv
// Loop host model: sends command tones and decodes reply tones
`timescale 1ns/100ps
`default_nettype none
module flm_loop_host #(
   parameter int unsigned BIT_CYCLES = 120,
   parameter int unsigned MARK_HALF  = 10,
   parameter int unsigned SPACE_HALF = 6
) (
   input  wire logic clock,
   output var  logic rxTone,
   input  wire logic txTone,
   input  wire logic txCarrierOn
);
   int unsigned phase = 0;
   int unsigned e = 0;
   initial rxTone = 1'b0;
   task automatic tick();
      @(posedge clock);
      #1;
      e++;
   endtask
   task automatic send_bit(input logic b);
      repeat (BIT_CYCLES) begin
         tick();
         phase++;
         if (phase >= (b ? MARK_HALF : SPACE_HALF)) begin
            rxTone = ~rxTone;
            phase = 0;
         end
      end
   endtask
   task automatic send_byte(input logic [7:0] d, input logic badPar,
                            input logic badStop);
      logic [10:0] f;
      f = {~badStop, ~^d ^ badPar, d, 1'b0};
      send_bit(1'b1);
      for (int i = 0; i < 11; i++) send_bit(f[i]);
   endtask
   // Line rests at mark between characters
   task automatic send_idle(input int unsigned n);
      repeat (n) send_bit(1'b1);
   endtask
   // half period length names the bit
   task automatic get_byte(output logic [10:0] f);
      int unsigned n;
      logic t;
      e = 0;
      while (!txCarrierOn && e < 40000) tick();
      e = 0;
      for (int i = 0; i < 11; i++) begin
         while (e < i * BIT_CYCLES + BIT_CYCLES / 4) tick();
         t = txTone;
         while (txTone == t && e < 20 * BIT_CYCLES) tick();
         t = txTone;
         n = 0;
         while (txTone == t && n < 4 * MARK_HALF) begin
            tick();
            n++;
         end
         f[i] = (n > (MARK_HALF + SPACE_HALF) / 2);
      end
   endtask
endmodule
`default_nettype wire

// File: testbench/fsk_loop_modem_framing_bench.sv
// Self-checking bench of the loop modem framer
`timescale 1ns/100ps
`default_nettype none
module fsk_loop_modem_framing_bench;
   localparam int unsigned BIT   = 120;
   localparam int unsigned MARKH = 10;
   localparam int unsigned SPCH  = 6;
   logic        clock = 1'b0;
   logic        arst_n = 1'b0;
   logic [15:0] processValue = '0;
   logic [14:0] loopMicroAmp;
   logic        rxTone, demodBit, txTone, txCarrierOn, txReady, txLast;
   logic        txValid = 1'b0;
   logic [7:0]  txData = '0;
   logic        rxValid, rxParityErr, rxFrameErr, responseArmed;
   logic [7:0]  rxData;
   int          errCount = 0;
   int          cmpCount = 0;
   logic [10:0] f;
   always #2 clock = ~clock;
   fsk_loop_modem_framing #(.BIT_CYCLES(BIT), .MARK_HALF(MARKH),
      .SPACE_HALF(SPCH), .DECIDE_CYCLES(16), .VALUE_BITS(16)) dut_u (
      .clock         (clock),
      .arst_n        (arst_n),
      .processValue  (processValue),
      .loopMicroAmp  (loopMicroAmp),
      .rxTone        (rxTone),
      .demodBit      (demodBit),
      .txTone        (txTone),
      .txCarrierOn   (txCarrierOn),
      .txValid       (txValid),
      .txData        (txData),
      .txLast        (txLast),
      .txReady       (txReady),
      .rxValid       (rxValid),
      .rxData        (rxData),
      .rxParityErr   (rxParityErr),
      .rxFrameErr    (rxFrameErr),
      .responseArmed (responseArmed)
   );
   flm_loop_host #(.BIT_CYCLES(BIT), .MARK_HALF(MARKH), .SPACE_HALF(SPCH))
      host_u (.clock(clock), .rxTone(rxTone), .txTone(txTone),
      .txCarrierOn(txCarrierOn));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmpCount++;
      if (seen !== exp) begin
         errCount++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic endSim();
      $display("checks %0d, errors %0d", cmpCount, errCount);
      if (errCount == 0 && cmpCount > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic t_current();
      logic [15:0] v [4] = '{16'h0000, 16'hffff, 16'h8000, 16'h0001};
      logic [31:0] e;
      logic        ok;
      foreach (v[i]) begin
         processValue = v[i];
         repeat (2) @(posedge clock);
         #1;
         e = 4000 + ((v[i] + 32'h1) * 16000 >> 16);
         check(loopMicroAmp, e);
         ok = (loopMicroAmp >= flm_pkg::FAULT_LOW_UA) &&
              (loopMicroAmp <= flm_pkg::FAULT_HIGH_UA);
         check(ok, 1'b1);
      end
   endtask
   task automatic t_refuse();
      txValid = 1'b1;
      repeat (300) @(posedge clock);
      #1;
      check({txCarrierOn, txReady, responseArmed}, 3'h0);
      txValid = 1'b0;
   endtask
   task automatic t_command(input logic [7:0] d, input logic badPar,
                            input logic badStop);
      host_u.send_byte(d, badPar, badStop);
      check(rxData, d);
      check({rxParityErr, rxFrameErr}, {badPar, badStop});
      check(responseArmed, 1'b1);
      // A zero stop reads as a new start, so rest long enough to flush it
      host_u.send_idle(badStop ? 12 : 1);
   endtask
   task automatic t_reply(input logic [7:0] d, input logic last);
      int k;
      txData = d;
      txLast = last;
      txValid = 1'b1;
      k = 0;
      while (txReady !== 1'b1 && k < 4000) begin
         @(posedge clock);
         #1;
         k++;
      end
      check(txReady, 1'b1);
      @(posedge clock);
      #1;
      txValid = 1'b0;
      host_u.get_byte(f);
      check(f, {1'b1, ~^d, d, 1'b0});
      repeat (BIT) @(posedge clock);
      #1;
      check({responseArmed, txCarrierOn}, {~last, 1'b0});
   endtask
   initial begin
      txLast = 1'b0;
      repeat (3) @(posedge clock);
      #1;
      arst_n = 1'b1;
      @(posedge clock);
      #1;
      check({demodBit, txTone, txReady, rxValid}, 4'h8);
      t_current();
      t_refuse();
      t_command(8'ha5, 1'b0, 1'b0);
      t_command(8'h5a, 1'b1, 1'b0);
      t_command(8'hc3, 1'b0, 1'b1);
      t_command(8'h01, 1'b0, 1'b0);
      t_reply(8'h3c, 1'b0);
      t_reply(8'h81, 1'b1);
      endSim();
   end
   initial begin
      #(4 * 60000);
      errCount++;
      endSim();
   end
endmodule
`default_nettype wire
